// >>> inc/scahr_pkg.sv
// Shared constants and types for the six channel hold and readout block.
// Assumes a single system clock; converter timing is in external clock periods.
package scahr_pkg;

    // External converter clock and phase times
    localparam int EXT_CLK_NS = 200;
    localparam int CONV_TIME_NS = 3200;
    localparam int ACQ_TIME_NS = 800;
    localparam int SAMPLE_RATE_KSPS = 250;
    localparam int THROUGHPUT_NS = 1000000 / SAMPLE_RATE_KSPS;
    localparam int CONV_PERIODS = CONV_TIME_NS / EXT_CLK_NS;
    localparam int ACQ_PERIODS = ACQ_TIME_NS / EXT_CLK_NS;
    localparam int CYCLE_PERIODS = THROUGHPUT_NS / EXT_CLK_NS;

    // Geometry
    localparam int NUM_PAIRS = 3;
    localparam int NUM_CHAN = 6;
    localparam int DATA_W = 16;
    localparam int CNT_W = 5;
    localparam int SYNC_W = 10;

    // Mode codes on the three address/mode inputs, channel bounds and FIFO limits
    localparam logic [2:0] MODE_LAST_DIRECT = 3'h5;
    localparam logic [2:0] MODE_CYCLE = 3'h6;
    localparam logic [2:0] MODE_FIFO = 3'h7;
    localparam logic [2:0] CHAN_FIRST = 3'h0;
    localparam logic [2:0] CHAN_LAST = 3'h5;
    localparam logic [2:0] FIFO_PAIR_LAST = 3'h4;
    localparam logic [2:0] FIFO_ROOM_MAX = 3'h4;

    // Address word: sync pattern, valid flag, channel address
    localparam logic [11:0] ADDR_SYNC = 12'hA50;

    // Reset values
    localparam logic [DATA_W-1:0] RESULT_RESET = 16'h0000;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 10'h01F;

    typedef enum logic [4:0] {
        PS_IDLE = 5'h01,
        PS_ARM = 5'h02,
        PS_CONV = 5'h04,
        PS_READY = 5'h08,
        PS_ACQ = 5'h10
    } scahr_pair_e;

endpackage

// >>> rtl/scahr_result_store.sv
// Six result words with channel tags and data-valid flags.
// Assumes writes come as a pair at an even base; read data is registered.
`timescale 1ns/1ns
module scahr_result_store #(
    parameter int DATA_W = 16,
    parameter int DEPTH = 6,
    parameter int AW = 3
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Pair write
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_base_i,
    input wire logic [DATA_W-1:0] wr_data0_i,
    input wire logic [DATA_W-1:0] wr_data1_i,
    input wire logic [2:0] wr_chan0_i,
    input wire logic [2:0] wr_chan1_i,
    // Valid clear after a read
    input wire logic clr_en_i,
    input wire logic [AW-1:0] clr_addr_i,
    // Read
    input wire logic [AW-1:0] rd_addr_i,
    output logic [DATA_W-1:0] rd_data_o,
    output logic [2:0] rd_chan_o,
    output logic rd_valid_o
);

    logic [DATA_W-1:0] data_q [DEPTH];
    logic [DATA_W-1:0] data_d [DEPTH];
    logic [2:0] chan_q [DEPTH];
    logic [2:0] chan_d [DEPTH];
    logic [DEPTH-1:0] valid_q, valid_d;
    logic [DATA_W-1:0] rdata_d;
    logic [2:0] rchan_d;
    logic rvalid_d;
    logic [AW-1:0] base1;

    assign base1 = AW'(wr_base_i + 1'b1);

    // Write after clear so a new result is never lost to a clear
    always_comb begin
        data_d = data_q;
        chan_d = chan_q;
        valid_d = valid_q;
        if (clr_en_i) begin
            valid_d[clr_addr_i] = 1'b0;
        end
        if (wr_en_i) begin
            data_d[wr_base_i] = wr_data0_i;
            data_d[base1] = wr_data1_i;
            chan_d[wr_base_i] = wr_chan0_i;
            chan_d[base1] = wr_chan1_i;
            valid_d[wr_base_i] = 1'b1;
            valid_d[base1] = 1'b1;
        end
        rdata_d = scahr_pkg::RESULT_RESET;
        rchan_d = 3'h0;
        rvalid_d = 1'b0;
        if (int'(rd_addr_i) < DEPTH) begin
            rdata_d = data_q[rd_addr_i];
            rchan_d = chan_q[rd_addr_i];
            rvalid_d = valid_q[rd_addr_i];
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                data_q[i] <= scahr_pkg::RESULT_RESET;
                chan_q[i] <= 3'h0;
            end
            valid_q <= '0;
            rd_data_o <= scahr_pkg::RESULT_RESET;
            rd_chan_o <= 3'h0;
            rd_valid_o <= 1'b0;
        end else begin
            data_q <= data_d;
            chan_q <= chan_d;
            valid_q <= valid_d;
            rd_data_o <= rdata_d;
            rd_chan_o <= rchan_d;
            rd_valid_o <= rvalid_d;
        end
    end

endmodule

// >>> rtl/scahr_top.sv
// Hold, conversion timing and parallel readout for six converters in three pairs.
// Assumes pins are asynchronous and results arrive from the converter core on clock_i.
//
// How it works
// - Three active-low hold inputs, one per pair
// - Hold fall holds and converts both pair channels
// - All holds together convert all six channels
// - End-of-conversion low half period per latch
// - Conversion 16 periods, acquisition four periods
// - Full cycle lasts twenty external clock periods when the pair latches at 16.5
// - External clock sets converter timing, except that a latch held off by a read comes at the end of that read
// - Reads allowed while conversion runs
// - Six result registers, one per channel except in FIFO mode, where they hold results in latch order
// - Each read gives one sixteen-bit word
// - Mode inputs pick direct, cycle or FIFO
// - FIFO returns results in latch order
// - FIFO holds six results, three pair latches
// - Codes 0-5 direct, 6 cycle, 7 FIFO
// - Hold pulses ignored until acquisition ends and the pair is idle
// - Latch at 16.5 periods, A then B then C
// - Latch waits while a read is active
`timescale 1ns/1ns
module scahr_top (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Converter clock and holds
    input wire logic conv_clk_i,
    input wire logic hold_pair_a_n_i,
    input wire logic hold_pair_b_n_i,
    input wire logic hold_pair_c_n_i,
    // Read control
    input wire logic mode_sel_bit0_i,
    input wire logic mode_sel_bit1_i,
    input wire logic mode_sel_bit2_i,
    input wire logic addr_word_en_i,
    input wire logic rd_n_i,
    input wire logic cs_n_i,
    // Converter core results, channel n at bits 16n+15..16n
    input wire logic [95:0] adc_result_i,
    // Outputs
    output logic [15:0] data_o,
    output logic data_oe_o,
    output logic eoc_n_o,
    output logic [2:0] pair_busy_o
);

    localparam int NP = scahr_pkg::NUM_PAIRS;
    localparam int DW = scahr_pkg::DATA_W;
    localparam int CW = scahr_pkg::CNT_W;
    localparam logic [CW-1:0] CONV_LAST = CW'(scahr_pkg::CONV_PERIODS);
    localparam logic [CW-1:0] ACQ_LAST = CW'(scahr_pkg::ACQ_PERIODS - 1);

    // Pin synchronisers
    logic [scahr_pkg::SYNC_W-1:0] sync1_q, sync2_q, sync3_q, pins;
    logic [2:0] hold_n, hold_prev, hold_fall, mode;
    logic ext_clk, ext_prev, rise_en, fall_en;
    logic rd_n, cs_n, add_en, read_act, read_prev, rd_end;

    assign pins = {conv_clk_i, addr_word_en_i, mode_sel_bit2_i, mode_sel_bit1_i,
                   mode_sel_bit0_i, cs_n_i, rd_n_i,
                   hold_pair_c_n_i, hold_pair_b_n_i, hold_pair_a_n_i};

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sync1_q <= scahr_pkg::SYNC_RESET;
            sync2_q <= scahr_pkg::SYNC_RESET;
            sync3_q <= scahr_pkg::SYNC_RESET;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign {ext_clk, add_en, mode, cs_n, rd_n, hold_n} = sync2_q;
    assign ext_prev = sync3_q[9];
    assign hold_prev = sync3_q[2:0];
    assign rise_en = ext_clk & ~ext_prev;
    assign fall_en = ~ext_clk & ext_prev;
    assign hold_fall = hold_prev & ~hold_n;
    assign read_act = ~rd_n & ~cs_n;
    assign read_prev = ~sync3_q[4] & ~sync3_q[3];
    assign rd_end = read_prev & ~read_act;

    // Pair state
    scahr_pkg::scahr_pair_e state_q [NP];
    scahr_pkg::scahr_pair_e state_d [NP];
    logic [CW-1:0] cnt_q [NP];
    logic [CW-1:0] cnt_d [NP];
    logic [NP-1:0] req, grant;
    logic latch_ok;

    // Latch only outside a read; priority A, B, C gives the one-period stagger
    assign latch_ok = ~read_act & (fall_en | rd_end);

    always_comb begin
        for (int p = 0; p < NP; p++) begin
            req[p] = (state_q[p] == scahr_pkg::PS_READY) ||
                     (state_q[p] == scahr_pkg::PS_CONV && fall_en &&
                      cnt_q[p] == CONV_LAST);
        end
        grant[0] = latch_ok & req[0];
        grant[1] = latch_ok & req[1] & ~req[0];
        grant[2] = latch_ok & req[2] & ~req[1] & ~req[0];
    end

    always_comb begin
        for (int p = 0; p < NP; p++) begin
            state_d[p] = state_q[p];
            cnt_d[p] = cnt_q[p];
            case (state_q[p])
                scahr_pkg::PS_IDLE: begin
                    if (hold_fall[p]) begin
                        state_d[p] = scahr_pkg::PS_ARM;
                    end
                end
                scahr_pkg::PS_ARM: begin
                    if (rise_en) begin
                        state_d[p] = scahr_pkg::PS_CONV;
                        cnt_d[p] = '0;
                    end
                end
                scahr_pkg::PS_CONV: begin
                    if (fall_en) begin
                        if (cnt_q[p] == CONV_LAST) begin
                            state_d[p] = grant[p] ? scahr_pkg::PS_ACQ : scahr_pkg::PS_READY;
                            cnt_d[p] = '0;
                        end else begin
                            cnt_d[p] = CW'(cnt_q[p] + 1'b1);
                        end
                    end
                end
                scahr_pkg::PS_READY: begin
                    if (grant[p]) begin
                        state_d[p] = scahr_pkg::PS_ACQ;
                        cnt_d[p] = '0;
                    end
                end
                scahr_pkg::PS_ACQ: begin
                    if (rise_en) begin
                        if (cnt_q[p] == ACQ_LAST) begin
                            state_d[p] = scahr_pkg::PS_IDLE;
                        end else begin
                            cnt_d[p] = CW'(cnt_q[p] + 1'b1);
                        end
                    end
                end
                default: begin
                    state_d[p] = scahr_pkg::PS_IDLE;
                    cnt_d[p] = '0;
                end
            endcase
        end
    end
    // Holds outside IDLE have no effect above

    // Read pointers and write selection
    logic [2:0] cyc_ptr_q, cyc_ptr_d, rptr_q, rptr_d, wptr_q, wptr_d;
    logic [2:0] count_q, count_d, raddr, wr_base, sel_pair, chan0;
    logic data_phase_q, data_phase_d, stream, fifo_mode, addr_phase;
    logic advance, pop, push, clr_en, wr_en, latch_any;
    logic [DW-1:0] wr_data0, wr_data1, mem_data, word;
    logic [2:0] mem_chan;
    logic mem_valid;

    assign fifo_mode = (mode == scahr_pkg::MODE_FIFO);
    assign stream = (mode == scahr_pkg::MODE_CYCLE) | fifo_mode;
    assign addr_phase = stream & add_en & ~data_phase_q;
    assign latch_any = |grant;

    always_comb begin
        sel_pair = 3'h0;
        if (grant[1]) begin
            sel_pair = 3'h1;
        end else if (grant[2]) begin
            sel_pair = 3'h2;
        end
        chan0 = 3'(sel_pair << 1);
        wr_data0 = adc_result_i[int'(chan0) * DW +: DW];
        wr_data1 = adc_result_i[(int'(chan0) + 1) * DW +: DW];
        push = latch_any & fifo_mode & (count_q <= scahr_pkg::FIFO_ROOM_MAX);
        wr_en = latch_any & (~fifo_mode | push);
        wr_base = fifo_mode ? wptr_q : chan0;
        if (mode <= scahr_pkg::MODE_LAST_DIRECT) begin
            raddr = mode;
        end else if (fifo_mode) begin
            raddr = rptr_q;
        end else begin
            raddr = cyc_ptr_q;
        end
        advance = rd_end & (~stream | ~add_en | data_phase_q);
        pop = advance & fifo_mode & (count_q != 3'h0);
        clr_en = advance & (~fifo_mode | pop);
        cyc_ptr_d = cyc_ptr_q;
        if (advance && mode == scahr_pkg::MODE_CYCLE) begin
            cyc_ptr_d = (cyc_ptr_q == scahr_pkg::CHAN_LAST) ? scahr_pkg::CHAN_FIRST
                                                            : 3'(cyc_ptr_q + 1'b1);
        end
        rptr_d = rptr_q;
        if (pop) begin
            rptr_d = (rptr_q == scahr_pkg::CHAN_LAST) ? scahr_pkg::CHAN_FIRST
                                                      : 3'(rptr_q + 1'b1);
        end
        wptr_d = wptr_q;
        if (push) begin
            wptr_d = (wptr_q == scahr_pkg::FIFO_PAIR_LAST) ? scahr_pkg::CHAN_FIRST
                                                           : 3'(wptr_q + 3'h2);
        end
        count_d = 3'(count_q + (push ? 3'h2 : 3'h0) - (pop ? 3'h1 : 3'h0));
        data_phase_d = data_phase_q;
        if (!stream || !add_en) begin
            data_phase_d = 1'b0;
        end else if (rd_end) begin
            data_phase_d = ~data_phase_q;
        end
    end

    scahr_result_store #(
        .DATA_W(DW),
        .DEPTH(scahr_pkg::NUM_CHAN),
        .AW(3)
    ) u_store (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .wr_en_i(wr_en),
        .wr_base_i(wr_base),
        .wr_data0_i(wr_data0),
        .wr_data1_i(wr_data1),
        .wr_chan0_i(chan0),
        .wr_chan1_i(3'(chan0 + 1'b1)),
        .clr_en_i(clr_en),
        .clr_addr_i(raddr),
        .rd_addr_i(raddr),
        .rd_data_o(mem_data),
        .rd_chan_o(mem_chan),
        .rd_valid_o(mem_valid)
    );

    // Output word and strobes
    logic [DW-1:0] data_q, data_d;
    logic oe_q, oe_d, eoc_n_q, eoc_n_d;
    logic [NP-1:0] busy_q, busy_d;

    always_comb begin
        word = addr_phase ? {scahr_pkg::ADDR_SYNC, mem_valid, mem_chan}
                          : mem_data;
        data_d = read_act ? word : data_q;
        oe_d = read_act;
        eoc_n_d = eoc_n_q;
        if (latch_any) begin
            eoc_n_d = 1'b0;
        end else if (rise_en | fall_en) begin
            eoc_n_d = 1'b1;
        end
        for (int p = 0; p < NP; p++) begin
            busy_d[p] = (state_d[p] != scahr_pkg::PS_IDLE);
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            for (int p = 0; p < NP; p++) begin
                state_q[p] <= scahr_pkg::PS_IDLE;
                cnt_q[p] <= '0;
            end
            cyc_ptr_q <= scahr_pkg::CHAN_FIRST;
            rptr_q <= scahr_pkg::CHAN_FIRST;
            wptr_q <= scahr_pkg::CHAN_FIRST;
            count_q <= 3'h0;
            data_phase_q <= 1'b0;
            data_q <= scahr_pkg::RESULT_RESET;
            oe_q <= 1'b0;
            eoc_n_q <= 1'b1;
            busy_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            cyc_ptr_q <= cyc_ptr_d;
            rptr_q <= rptr_d;
            wptr_q <= wptr_d;
            count_q <= count_d;
            data_phase_q <= data_phase_d;
            data_q <= data_d;
            oe_q <= oe_d;
            eoc_n_q <= eoc_n_d;
            busy_q <= busy_d;
        end
    end

    assign data_o = data_q;
    assign data_oe_o = oe_q;
    assign eoc_n_o = eoc_n_q;
    assign pair_busy_o = busy_q;

endmodule

// >>> testbench/scahr_host_model.sv
// Host model: reads words over the parallel bus with read and select strobes.
// Assumes the bench calls rd_word; pins change only at the falling clock edge.
`timescale 1ns/1ns
module scahr_host_model (
    // Clock
    input wire logic clock_i,
    // Bus from device
    input wire logic [15:0] data_i,
    input wire logic data_oe_i,
    // Strobes and mode
    output logic rd_n_o,
    output logic cs_n_o,
    output logic [2:0] mode_o
);
    initial begin
        rd_n_o = 1'b1;
        cs_n_o = 1'b1;
        mode_o = 3'h0;
    end
    // One read; strobes stay low for extra cycles after the answer
    task automatic rd_word(input logic [2:0] mode, input int extra,
        output logic [15:0] word, output bit ok);
        int i;
        ok = 1'b0;
        word = 16'h0000;
        @(negedge clock_i);
        mode_o = mode;
        repeat (4) @(negedge clock_i);
        cs_n_o = 1'b0;
        rd_n_o = 1'b0;
        for (i = 0; i < 20 && !ok; i++) begin
            @(negedge clock_i);
            if (data_oe_i === 1'b1) begin
                ok = 1'b1;
                word = data_i;
            end
        end
        repeat (extra) @(posedge clock_i);
        @(negedge clock_i);
        rd_n_o = 1'b1;
        cs_n_o = 1'b1;
        repeat (6) @(negedge clock_i);
    endtask
endmodule

// >>> testbench/scahr_top_assertions.sv
// Checker on the pins of the hold and readout block.
// Assumes one clock domain and a synchronous active high reset.
`timescale 1ns/1ns
module scahr_top_assertions (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Inputs watched
    input wire logic hold_pair_a_n_i,
    input wire logic hold_pair_c_n_i,
    input wire logic rd_n_i,
    input wire logic cs_n_i,
    // Outputs watched
    input wire logic [15:0] data_o,
    input wire logic data_oe_o,
    input wire logic eoc_n_o,
    input wire logic [2:0] pair_busy_o
);
    logic [9:0] busy_cnt_q;
    logic [9:0] busy_cnt_d;
    always_comb begin
        busy_cnt_d = pair_busy_o[0] ? busy_cnt_q + 10'h001 : 10'h000;
    end
    always_ff @(posedge clock_i) begin
        busy_cnt_q <= rst_i ? 10'h000 : busy_cnt_d;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    property p_oe_follows;
        data_oe_o == $past(!rd_n_i && !cs_n_i, 3);
    endproperty
    a_oe_follows: assert property (p_oe_follows) else $error("bus enable off strobes");
    property p_eoc_width;
        $fell(eoc_n_o) |-> ##[1:12] eoc_n_o;
    endproperty
    a_eoc_width: assert property (p_eoc_width) else $error("eoc low too long");
    property p_latch_after_read;
        $fell(eoc_n_o) |-> !data_oe_o;
    endproperty
    a_latch_after_read: assert property (p_latch_after_read) else $error("latch in read");
    property p_hold_arm_a;
        $fell(hold_pair_a_n_i) && !pair_busy_o[0] |-> ##4 pair_busy_o[0];
    endproperty
    a_hold_arm_a: assert property (p_hold_arm_a) else $error("pair a not started");
    property p_hold_arm_c;
        $fell(hold_pair_c_n_i) && !pair_busy_o[2] |-> ##4 pair_busy_o[2];
    endproperty
    a_hold_arm_c: assert property (p_hold_arm_c) else $error("pair c not started");
    property p_cycle_len;
        $fell(pair_busy_o[0]) |-> busy_cnt_q >= 10'h18B && busy_cnt_q <= 10'h1A9;
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("cycle length off");
    property p_conv_len;
        $fell(eoc_n_o) && pair_busy_o == 3'h1 |-> busy_cnt_q >= 10'h145 && busy_cnt_q <= 10'h164;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length off");
    property p_data_stable;
        data_oe_o && $past(data_oe_o) |-> $stable(data_o);
    endproperty
    a_data_stable: assert property (p_data_stable) else $error("word moved in read");
    property p_reset_idle;
        disable iff (1'b0) rst_i |=> !data_oe_o && eoc_n_o && pair_busy_o == 3'h0;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle in reset");
    c_eoc: cover property ($fell(eoc_n_o));
    c_read: cover property ($rose(data_oe_o));
    c_all_busy: cover property (pair_busy_o == 3'h7);
endmodule
bind scahr_top scahr_top_assertions u_chk (.clock_i, .rst_i, .hold_pair_a_n_i,
    .hold_pair_c_n_i, .rd_n_i, .cs_n_i, .data_o, .data_oe_o, .eoc_n_o, .pair_busy_o);

// >>> testbench/test_six_channel_adc_hold_and_readout.sv
// Bench for the six channel hold and readout block.
// Assumes the host model drives strobes and mode; the bench drives holds and clocks.
`timescale 1ns/1ns
module test_six_channel_adc_hold_and_readout;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic conv_clk = 1'b0;
    logic [2:0] hold_n = 3'h7;
    logic addr_en = 1'b0;
    logic [95:0] adc = 96'h0;
    logic rd_n, cs_n, data_oe_o, eoc_n_o;
    logic [2:0] mode, pair_busy_o;
    logic [15:0] data_o;
    int n_mismatch = 0;
    int comparisons = 0;
    always #5 clock_i = ~clock_i;
    always #100 conv_clk = ~conv_clk;
    scahr_top u_dut (.clock_i, .rst_i, .conv_clk_i(conv_clk), .hold_pair_a_n_i(hold_n[0]),
        .hold_pair_b_n_i(hold_n[1]), .hold_pair_c_n_i(hold_n[2]), .mode_sel_bit0_i(mode[0]),
        .mode_sel_bit1_i(mode[1]), .mode_sel_bit2_i(mode[2]), .addr_word_en_i(addr_en),
        .rd_n_i(rd_n), .cs_n_i(cs_n), .adc_result_i(adc), .data_o, .data_oe_o, .eoc_n_o,
        .pair_busy_o);
    scahr_host_model u_host (.clock_i, .data_i(data_o), .data_oe_i(data_oe_o),
        .rd_n_o(rd_n), .cs_n_o(cs_n), .mode_o(mode));
    task automatic wrap_up();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic stall(input string what);
        n_mismatch++;
        $display("MISMATCH %s expected done seen timeout", what);
        wrap_up();
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [2:0] m, input int extra, input logic [15:0] exp,
        input string what);
        logic [15:0] w;
        bit ok;
        u_host.rd_word(m, extra, w, ok);
        if (!ok) stall(what);
        check(what, exp, w);
    endtask
    function automatic logic [95:0] pat(input logic [15:0] b);
        for (int n = 0; n < 6; n++) pat[16*n +: 16] = b + 16'(n);
    endfunction
    task automatic do_reset();
        @(negedge clock_i);
        rst_i = 1'b1;
        repeat (6) @(negedge clock_i);
        rst_i = 1'b0;
        repeat (2) @(negedge clock_i);
    endtask
    // Start pairs in mask, pulse the holds again mid-run, count eoc falls
    task automatic run_conv(input logic [2:0] mask, output int falls, output int gap);
        int i, last;
        logic pe;
        falls = 0;
        gap = 0;
        last = 0;
        pe = 1'b1;
        @(negedge clock_i);
        hold_n = ~mask;
        for (i = 1; i < 900; i++) begin
            @(negedge clock_i);
            if (i == 4 || i == 104) hold_n = 3'h7;
            if (i == 100) hold_n = ~mask;
            if (pe === 1'b1 && eoc_n_o === 1'b0) begin
                if (falls > 0) gap = i - last;
                last = i;
                falls++;
            end
            pe = eoc_n_o;
            if (i > 10 && pair_busy_o === 3'h0) break;
        end
        if (i >= 900) stall("conversion");
    endtask
    task automatic t_single();
        int f, g;
        check("data_oe_o", 16'h0000, {15'h0, data_oe_o});
        check("pair_busy_o", 16'h0000, {13'h0, pair_busy_o});
        adc = pat(16'h1100);
        run_conv(3'h1, f, g);
        check("eoc falls", 16'h0001, 16'(f));
        rd(3'h0, 0, 16'h1100, "ch0");
        rd(3'h1, 0, 16'h1101, "ch1");
        rd(3'h2, 0, 16'h0000, "ch2");
        $display("t_single done");
    endtask
    task automatic t_cycle();
        int f, g, i;
        do_reset();
        adc = pat(16'h2200);
        run_conv(3'h7, f, g);
        check("eoc falls", 16'h0003, 16'(f));
        check("latch gap", 16'h0014, 16'(g));
        for (i = 0; i < 7; i++) rd(3'h6, 0, 16'h2200 + 16'(i % 6), "cycle");
        for (i = 5; i >= 0; i--) rd(3'(i), 0, 16'h2200 + 16'(i), "direct");
        $display("t_cycle done");
    endtask
    task automatic t_fifo();
        int f, g, i;
        logic [15:0] want [5] = '{16'h3303, 16'h4400, 16'h4401, 16'h5502, 16'h5503};
        do_reset();
        rd(3'h7, 0, 16'h0000, "empty fifo");
        adc = pat(16'h3300);
        run_conv(3'h2, f, g);
        adc = pat(16'h4400);
        run_conv(3'h1, f, g);
        adc = pat(16'h5500);
        run_conv(3'h2, f, g);
        check("eoc falls", 16'h0001, 16'(f));
        addr_en = 1'b1;
        rd(3'h7, 0, {scahr_pkg::ADDR_SYNC, 1'b1, 3'h2}, "address word");
        rd(3'h7, 0, 16'h3302, "fifo");
        addr_en = 1'b0;
        for (i = 0; i < 5; i++) rd(3'h7, 0, want[i], "fifo");
        $display("t_fifo done");
    endtask
    task automatic t_postpone();
        int i;
        do_reset();
        adc = pat(16'h6600);
        hold_n = 3'h3;
        repeat (4) @(negedge clock_i);
        hold_n = 3'h7;
        repeat (300) @(negedge clock_i);
        rd(3'h4, 90, 16'h0000, "read across latch");
        for (i = 0; i < 900 && pair_busy_o !== 3'h0; i++) @(negedge clock_i);
        if (i >= 900) stall("idle");
        rd(3'h4, 0, 16'h6604, "after latch");
        $display("t_postpone done");
    endtask
    initial begin
        do_reset();
        t_single();
        t_cycle();
        t_fifo();
        t_postpone();
        wrap_up();
    end
endmodule
